/* src/ema_pkg.sv */
package ema_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [15:0] ADDR_FRAMING_SELECT = 16'h0107;
    localparam logic [15:0] ADDR_FRAMING_CONTROL = 16'h010B;
    localparam logic [15:0] ADDR_INT_STATUS = 16'h0B0A;
    localparam logic [15:0] ADDR_INT_CLEAR = 16'h0B0B;
    localparam logic [15:0] ADDR_INT_ENABLE = 16'h0B0C;
    localparam logic [15:0] ADDR_LINE_STATE = 16'h0B0D;

    localparam logic [7:0] FRAMING_SELECT_RST = 8'h00;
    localparam logic [7:0] FRAMING_CONTROL_RST = 8'h01;
    localparam logic [7:0] INT_ENABLE_RST = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int FS_INTERWORK_BIT = 7;
    localparam int FS_TX_CRC_ERR_BIT = 6;
    localparam int FS_CAS_SEL_HI = 5;
    localparam int FS_CAS_SEL_LO = 4;
    localparam int FS_CRC_SEL_HI = 3;
    localparam int FS_CRC_SEL_LO = 2;
    localparam int FC_LOSS_HI = 1;
    localparam int FC_LOSS_LO = 0;

    // Interrupt status bits
    localparam int NUM_EVENTS = 3;
    localparam int EV_INTERWORK = 0;
    localparam int EV_CAS_ALIGN = 1;
    localparam int EV_CAS_LOSS = 2;

    // ****************************************************************
    // Codes and counts
    // ****************************************************************
    localparam logic [1:0] CAS_SEL_16FRAME = 2'h1;
    localparam logic [1:0] CAS_SEL_2FRAME = 2'h2;
    localparam logic [1:0] CRC_SEL_OFF = 2'h0;
    localparam logic [3:0] CAS_MF_PATTERN = 4'h0;
    localparam logic [3:0] CAS_MISS_16FRAME = 4'hF;
    localparam logic [3:0] CAS_MISS_2FRAME = 4'h1;
    localparam logic [3:0] FRAMES_PER_MF_LAST = 4'hF;

    // Interworking timeout
    localparam int CLK_KHZ = 100000;
    localparam int INTERWORK_MS = 400;
    localparam int INTERWORK_CYCLES = INTERWORK_MS * CLK_KHZ;
    localparam int TIMER_W = 26;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic stb;
        logic [7:0] ts16;
    } ema_rx_frame_t;

    typedef struct packed {
        logic stb;
        logic bit_val;
    } ema_crc_bit_t;

    typedef enum logic [1:0] {
        CAS_OFF,
        CAS_HUNT,
        CAS_SYNC
    } ema_cas_state_t;

endpackage : ema_pkg

/* src/ema_top.sv */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Framing select bit 7 turns the CRC-to-non-CRC interworking search on, and 0 turns it off.
// - With interworking and CRC alignment on, 400 ms of basic frame alignment without CRC
//      multiframe alignment means the far end has no CRC-4.
// - That conclusion raises an interworking interrupt whose status reads at 0x0B0A.
// - Bit 6 inverts the first CRC bit of every outgoing multiframe; at 0 CRC goes out clean.
// - The forced CRC error is ignored while CRC multiframing is disabled.
// - CAS select values 00 and 11 disable CAS multiframe alignment.
// - While CAS alignment is on, bits 1 to 4 of timeslot 16 of every frame are checked.
// - Select 01 declares alignment after 15 frames without the pattern then one with it.
// - Select 10 declares alignment after one frame without the pattern then one with it.
// - CRC select 00 disables CRC multiframe alignment and the forced CRC error.
module ema_top #(
    parameter int INTERWORK_CYCLES = ema_pkg::INTERWORK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire ema_pkg::ema_rx_frame_t rx_frame,
    input wire logic rx_fas_present,
    input wire logic rx_crc_mf_aligned,
    input wire ema_pkg::ema_crc_bit_t tx_c1_in,
    output ema_pkg::ema_crc_bit_t tx_c1_out,
    output logic crc_mf_enable,
    output logic interwork_enable,
    output logic remote_no_crc4,
    output logic cas_mf_aligned,
    output logic cas_mf_loss,
    output logic irq
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic logic cas_sel_on(input logic [1:0] sel);
        cas_sel_on = (sel == ema_pkg::CAS_SEL_16FRAME) || (sel == ema_pkg::CAS_SEL_2FRAME);
    endfunction : cas_sel_on

    function automatic logic [3:0] cas_miss_need(input logic [1:0] sel);
        if (sel == ema_pkg::CAS_SEL_16FRAME) begin
            cas_miss_need = ema_pkg::CAS_MISS_16FRAME;
        end else begin
            cas_miss_need = ema_pkg::CAS_MISS_2FRAME;
        end
    endfunction : cas_miss_need

    function automatic logic reg_hit(input logic [15:0] a, input logic [15:0] target);
        reg_hit = (a == target);
    endfunction : reg_hit

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] framing_select_r;
    logic [7:0] framing_control_r;
    logic [ema_pkg::NUM_EVENTS-1:0] int_status_r;
    logic [ema_pkg::NUM_EVENTS-1:0] int_enable_r;
    logic [ema_pkg::NUM_EVENTS-1:0] int_clear;
    logic [ema_pkg::NUM_EVENTS-1:0] int_event;
    logic [7:0] rdata_nxt;

    logic [1:0] cas_sel;
    logic [1:0] crc_sel;
    logic crc_on;
    logic cas_on;

    assign cas_sel = framing_select_r[ema_pkg::FS_CAS_SEL_HI:ema_pkg::FS_CAS_SEL_LO];
    assign crc_sel = framing_select_r[ema_pkg::FS_CRC_SEL_HI:ema_pkg::FS_CRC_SEL_LO];
    assign crc_on = (crc_sel != ema_pkg::CRC_SEL_OFF);
    assign cas_on = cas_sel_on(cas_sel);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            framing_select_r <= ema_pkg::FRAMING_SELECT_RST;
        end else if (clk_en && reg_wr && reg_hit(reg_addr, ema_pkg::ADDR_FRAMING_SELECT)) begin
            framing_select_r <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            framing_control_r <= ema_pkg::FRAMING_CONTROL_RST;
        end else if (clk_en && reg_wr && reg_hit(reg_addr, ema_pkg::ADDR_FRAMING_CONTROL)) begin
            framing_control_r <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            int_enable_r <= ema_pkg::INT_ENABLE_RST[ema_pkg::NUM_EVENTS-1:0];
        end else if (clk_en && reg_wr && reg_hit(reg_addr, ema_pkg::ADDR_INT_ENABLE)) begin
            int_enable_r <= reg_wdata[ema_pkg::NUM_EVENTS-1:0];
        end
    end

    // Write-one-to-clear strobe, no storage behind it
    assign int_clear = (reg_wr && reg_hit(reg_addr, ema_pkg::ADDR_INT_CLEAR))
        ? reg_wdata[ema_pkg::NUM_EVENTS-1:0] : '0;

    // ****************************************************************
    // Sticky status
    // ****************************************************************
    // A set in the same cycle as its clear wins, so no event is lost
    for (genvar i = 0; i < ema_pkg::NUM_EVENTS; i++) begin : g_status
        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                int_status_r[i] <= 1'b0;
            end else if (clk_en) begin
                if (int_event[i]) begin
                    int_status_r[i] <= 1'b1;
                end else if (int_clear[i]) begin
                    int_status_r[i] <= 1'b0;
                end
            end
        end
    end

    assign irq = |(int_status_r & int_enable_r);

    // ****************************************************************
    // Read port
    // ****************************************************************
    always_comb begin
        rdata_nxt = ema_pkg::RDATA_UNMAPPED;
        if (reg_hit(reg_addr, ema_pkg::ADDR_FRAMING_SELECT)) begin
            rdata_nxt = framing_select_r;
        end else if (reg_hit(reg_addr, ema_pkg::ADDR_FRAMING_CONTROL)) begin
            rdata_nxt = framing_control_r;
        end else if (reg_hit(reg_addr, ema_pkg::ADDR_INT_STATUS)) begin
            rdata_nxt = {5'h00, int_status_r};
        end else if (reg_hit(reg_addr, ema_pkg::ADDR_INT_ENABLE)) begin
            rdata_nxt = {5'h00, int_enable_r};
        end else if (reg_hit(reg_addr, ema_pkg::ADDR_LINE_STATE)) begin
            rdata_nxt = {5'h00, remote_no_crc4, cas_mf_loss, cas_mf_aligned};
        end
    end

    // Data only stands in the cycle after the read strobe
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
        end
    end

    // ****************************************************************
    // CRC-4 interworking timer
    // ****************************************************************
    logic [ema_pkg::TIMER_W-1:0] iw_count_r;
    logic remote_no_crc4_r;
    logic iw_run;
    logic iw_expire;

    // search only when bit 7 set
    assign interwork_enable = framing_select_r[ema_pkg::FS_INTERWORK_BIT];
    assign crc_mf_enable = crc_on;
    // runs while FAS present and CRC MF not yet found
    assign iw_run = interwork_enable && crc_on && rx_fas_present && !rx_crc_mf_aligned;
    assign iw_expire = iw_run && !remote_no_crc4_r
        && (iw_count_r == ema_pkg::TIMER_W'(INTERWORK_CYCLES - 1));

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            iw_count_r <= '0;
        end else if (clk_en) begin
            if (!iw_run || iw_expire) begin
                iw_count_r <= '0;
            end else if (!remote_no_crc4_r) begin
                iw_count_r <= iw_count_r + 1'b1;
            end
        end
    end

    // Conclusion is held while the search conditions persist
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            remote_no_crc4_r <= 1'b0;
        end else if (clk_en) begin
            if (iw_expire) begin
                remote_no_crc4_r <= 1'b1;
            end else if (!iw_run) begin
                remote_no_crc4_r <= 1'b0;
            end
        end
    end

    assign remote_no_crc4 = remote_no_crc4_r;

    // ****************************************************************
    // CAS multiframe alignment
    // ****************************************************************
    ema_pkg::ema_cas_state_t cas_state_r;
    logic [3:0] miss_run_r;
    logic [3:0] frame_pos_r;
    logic [1:0] loss_miss_r;
    logic pattern_seen;
    logic cas_declare;
    logic cas_lose;

    localparam logic [3:0] FRAMES_LAST = ema_pkg::FRAMES_PER_MF_LAST;

    // bits 1-4 of timeslot 16, first bit in the MSB
    assign pattern_seen = (rx_frame.ts16[7:4] == ema_pkg::CAS_MF_PATTERN);
    // declare after the required run of misses
    assign cas_declare = cas_on && rx_frame.stb && pattern_seen
        && (cas_state_r == ema_pkg::CAS_HUNT) && (miss_run_r >= cas_miss_need(cas_sel));
    // loss on the missed pattern slot that follows the configured number of earlier misses
    assign cas_lose = (cas_state_r == ema_pkg::CAS_SYNC) && rx_frame.stb
        && (frame_pos_r == FRAMES_LAST) && !pattern_seen
        && (loss_miss_r == framing_control_r[ema_pkg::FC_LOSS_HI:ema_pkg::FC_LOSS_LO]);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cas_state_r <= ema_pkg::CAS_OFF;
        end else if (clk_en) begin
            unique case (cas_state_r)
                ema_pkg::CAS_OFF: begin
                    if (cas_on) begin
                        cas_state_r <= ema_pkg::CAS_HUNT;
                    end
                end
                ema_pkg::CAS_HUNT: begin
                    if (!cas_on) begin
                        cas_state_r <= ema_pkg::CAS_OFF;
                    end else if (cas_declare) begin
                        cas_state_r <= ema_pkg::CAS_SYNC;
                    end
                end
                ema_pkg::CAS_SYNC: begin
                    if (!cas_on) begin
                        cas_state_r <= ema_pkg::CAS_OFF;
                    end else if (cas_lose) begin
                        cas_state_r <= ema_pkg::CAS_HUNT;
                    end
                end
                default: begin
                    cas_state_r <= ema_pkg::CAS_OFF;
                end
            endcase
        end
    end

    // Run of consecutive frames without the pattern, saturating
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            miss_run_r <= 4'h0;
        end else if (clk_en) begin
            if (!cas_on) begin
                miss_run_r <= 4'h0;
            end else if (rx_frame.stb) begin
                if (pattern_seen) begin
                    miss_run_r <= 4'h0;
                end else if (miss_run_r != 4'hF) begin
                    miss_run_r <= miss_run_r + 4'h1;
                end
            end
        end
    end

    // Frame position inside the multiframe once aligned
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_pos_r <= 4'h0;
        end else if (clk_en && rx_frame.stb) begin
            if (cas_declare) begin
                frame_pos_r <= 4'h0;
            end else begin
                frame_pos_r <= frame_pos_r + 4'h1;
            end
        end
    end

    // Consecutive multiframes whose pattern slot was wrong
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            loss_miss_r <= 2'h0;
        end else if (clk_en) begin
            if (cas_declare || cas_state_r != ema_pkg::CAS_SYNC) begin
                loss_miss_r <= 2'h0;
            end else if (rx_frame.stb && frame_pos_r == FRAMES_LAST) begin
                if (pattern_seen || cas_lose) begin
                    loss_miss_r <= 2'h0;
                end else begin
                    loss_miss_r <= loss_miss_r + 2'h1;
                end
            end
        end
    end

    // loss holds until declaration clears it
    assign cas_mf_aligned = (cas_state_r == ema_pkg::CAS_SYNC);
    assign cas_mf_loss = !cas_mf_aligned;

    assign int_event[ema_pkg::EV_INTERWORK] = iw_expire;
    assign int_event[ema_pkg::EV_CAS_ALIGN] = cas_declare;
    assign int_event[ema_pkg::EV_CAS_LOSS] = cas_lose;

    // ****************************************************************
    // Transmit C1 corruption
    // ****************************************************************
    logic force_c1;

    // invert C1 when bit 6 set
    // ignored while CRC multiframing is off
    assign force_c1 = framing_select_r[ema_pkg::FS_TX_CRC_ERR_BIT] && crc_on;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_c1_out <= '0;
        end else if (clk_en) begin
            tx_c1_out.stb <= tx_c1_in.stb;
            tx_c1_out.bit_val <= tx_c1_in.stb ? (tx_c1_in.bit_val ^ force_c1) : 1'b0;
        end
    end

endmodule : ema_top

`default_nettype wire

/* bench/ema_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module ema_top_properties #(
    parameter int INTERWORK_CYCLES = 50
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire ema_pkg::ema_rx_frame_t rx_frame,
    input wire logic rx_fas_present,
    input wire logic rx_crc_mf_aligned,
    input wire ema_pkg::ema_crc_bit_t tx_c1_in,
    input wire ema_pkg::ema_crc_bit_t tx_c1_out,
    input wire logic crc_mf_enable,
    input wire logic interwork_enable,
    input wire logic remote_no_crc4,
    input wire logic cas_mf_aligned,
    input wire logic cas_mf_loss,
    input wire logic irq
);
    // ****************************************************************
    // Helper logic
    // ****************************************************************
    logic [7:0] fs_r;
    int cnt_r;
    logic iw_go;
    logic cas_off;
    // Mirror of the select register, since the checker sees only ports
    assign iw_go = fs_r[7] && fs_r[3:2] != 2'h0 && rx_fas_present && !rx_crc_mf_aligned;
    assign cas_off = fs_r[5:4] == 2'h0 || fs_r[5:4] == 2'h3;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fs_r <= ema_pkg::FRAMING_SELECT_RST;
        end else if (clk_en && reg_wr && reg_addr == ema_pkg::ADDR_FRAMING_SELECT) begin
            fs_r <= reg_wdata;
        end
    end
    // Any drop of the run condition restarts the count
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 0;
        end else if (clk_en) begin
            cnt_r <= iw_go ? cnt_r + 1 : 0;
        end
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_iw_map: assert property (interwork_enable == fs_r[7])
        else $error("interwork enable does not follow select");
    a_crc_map: assert property (crc_mf_enable == (fs_r[3:2] != 2'h0))
        else $error("crc enable does not follow select");
    a_iw_time: assert property ($rose(remote_no_crc4) |-> cnt_r == INTERWORK_CYCLES)
        else $error("interworking verdict at wrong time");
    a_iw_hold: assert property (cnt_r >= INTERWORK_CYCLES |-> remote_no_crc4)
        else $error("interworking verdict missing");
    a_c1_force: assert property (clk_en && tx_c1_in.stb |=> tx_c1_out.stb &&
        tx_c1_out.bit_val == ($past(tx_c1_in.bit_val) ^ ($past(fs_r[6]) && $past(fs_r[3:2]) != 2'h0)))
        else $error("outgoing crc bit wrong");
    a_cas_off: assert property (cas_off ##1 cas_off |-> !cas_mf_aligned)
        else $error("cas alignment while disabled");
    a_cas_cause: assert property ($rose(cas_mf_aligned) |-> $past(rx_frame.stb) &&
        $past(rx_frame.ts16[7:4]) == ema_pkg::CAS_MF_PATTERN)
        else $error("cas alignment without pattern frame");
    a_loss_inv: assert property (cas_mf_loss == !cas_mf_aligned)
        else $error("cas loss not inverse of alignment");
    a_loss_hold: assert property (cas_mf_loss && !(rx_frame.stb &&
        rx_frame.ts16[7:4] == ema_pkg::CAS_MF_PATTERN) |=> cas_mf_loss)
        else $error("cas loss cleared without pattern frame");
    c_cas: cover property ($rose(cas_mf_aligned));
    c_iw: cover property ($rose(remote_no_crc4));
    c_c1: cover property (tx_c1_out.stb && tx_c1_out.bit_val);
endmodule : ema_top_properties
`default_nettype wire

/* bench/ema_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
// Far terminal: n_miss frames without the pattern, then one with it
module ema_far_end (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic go,
    input wire logic [4:0] n_miss,
    output ema_pkg::ema_rx_frame_t rx_frame,
    output logic busy
);
    logic [4:0] left_r;
    logic [1:0] gap_r;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
            left_r <= 5'h00;
            gap_r <= 2'h0;
            rx_frame <= '0;
        end else if (go) begin
            busy <= 1'b1;
            left_r <= n_miss;
            gap_r <= 2'h0;
            rx_frame.stb <= 1'b0;
        end else if (busy && gap_r == 2'h3) begin
            rx_frame.stb <= 1'b1;
            // Low nibble nonzero so only bits 1 to 4 can decide
            rx_frame.ts16 <= (left_r == 5'h00) ? 8'h05 : 8'hF5;
            busy <= left_r != 5'h00;
            left_r <= left_r - 5'h01;
            gap_r <= 2'h0;
        end else begin
            // Outside a frame the byte is not held
            rx_frame.stb <= 1'b0;
            rx_frame.ts16 <= ~rx_frame.ts16;
            gap_r <= gap_r + 2'h1;
        end
    end
endmodule : ema_far_end
`default_nettype wire

/* bench/test_ema_top.sv */
`timescale 1ns/1ps
`default_nettype none
module test_ema_top;
    localparam int N_IW = 50;
    logic core_clk, rst_b, clk_en, reg_wr, reg_rd, rx_fas_present, rx_crc_mf_aligned, go, busy;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd_v;
    logic [4:0] n_miss;
    ema_pkg::ema_rx_frame_t rx_frame;
    ema_pkg::ema_crc_bit_t tx_c1_in, tx_c1_out;
    logic crc_mf_enable, interwork_enable, remote_no_crc4, cas_mf_aligned, cas_mf_loss, irq;
    int n_mismatch, n_checks, n_cyc;
    ema_top #(.INTERWORK_CYCLES(N_IW)) ema_top_i (.core_clk(core_clk), .rst_b(rst_b),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_frame(rx_frame),
        .rx_fas_present(rx_fas_present), .rx_crc_mf_aligned(rx_crc_mf_aligned),
        .tx_c1_in(tx_c1_in), .tx_c1_out(tx_c1_out), .crc_mf_enable(crc_mf_enable),
        .interwork_enable(interwork_enable), .remote_no_crc4(remote_no_crc4),
        .cas_mf_aligned(cas_mf_aligned), .cas_mf_loss(cas_mf_loss), .irq(irq));
    ema_far_end ema_far_end_i (.core_clk(core_clk), .rst_b(rst_b), .go(go), .n_miss(n_miss),
        .rx_frame(rx_frame), .busy(busy));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic complete_run;
        $display("mismatches %0d checks %0d", n_mismatch, n_checks);
        if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic chk1(string what, logic e, logic s);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s expected %b seen %b", what, e, s);
        end
    endtask : chk1
    task automatic chk8(string what, logic [7:0] e, logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask : chk8
    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(logic [15:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask : rd
    task automatic frames(logic [4:0] n);
        @(posedge core_clk);
        go <= 1'b1;
        n_miss <= n;
        @(posedge core_clk);
        go <= 1'b0;
        #1;
        for (int i = 0; i < 200 && busy; i++) begin
            @(posedge core_clk);
            #1;
        end
        repeat (2) @(posedge core_clk);
        #1;
    endtask : frames
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs;
        rd(ema_pkg::ADDR_FRAMING_SELECT);
        chk8("select reset", ema_pkg::FRAMING_SELECT_RST, rd_v);
        chk1("loss at reset", 1'b1, cas_mf_loss);
        wr(ema_pkg::ADDR_FRAMING_SELECT, 8'hA6);
        rd(ema_pkg::ADDR_FRAMING_SELECT);
        chk8("select back", 8'hA6, rd_v);
        rd(16'h0200);
        chk8("unmapped", ema_pkg::RDATA_UNMAPPED, rd_v);
        wr(ema_pkg::ADDR_INT_STATUS, 8'hFF);
        rd(ema_pkg::ADDR_INT_STATUS);
        chk8("status read only", 8'h00, rd_v);
    endtask : t_regs
    task automatic t_cas;
        wr(ema_pkg::ADDR_FRAMING_SELECT, 8'h00);
        wr(ema_pkg::ADDR_FRAMING_SELECT, 8'h10);
        frames(5'd14);
        chk1("16 frame short run", 1'b0, cas_mf_aligned);
        frames(5'd15);
        chk1("16 frame aligned", 1'b1, cas_mf_aligned);
        chk1("16 frame loss", 1'b0, cas_mf_loss);
        rd(ema_pkg::ADDR_INT_STATUS);
        chk1("align status", 1'b1, rd_v[ema_pkg::EV_CAS_ALIGN]);
        wr(ema_pkg::ADDR_FRAMING_SELECT, 8'h00);
        wr(ema_pkg::ADDR_FRAMING_SELECT, 8'h20);
        frames(5'd0);
        chk1("2 frame no run", 1'b0, cas_mf_aligned);
        frames(5'd1);
        chk1("2 frame aligned", 1'b1, cas_mf_aligned);
        wr(ema_pkg::ADDR_FRAMING_CONTROL, 8'h00);
        frames(5'd16);
        rd(ema_pkg::ADDR_INT_STATUS);
        chk1("loss status", 1'b1, rd_v[ema_pkg::EV_CAS_LOSS]);
        wr(ema_pkg::ADDR_FRAMING_SELECT, 8'h30);
        frames(5'd1);
        chk1("cas off", 1'b0, cas_mf_aligned);
    endtask : t_cas
    // Every CRC select against both force settings and both bit values
    task automatic t_tx;
        for (int c = 0; c < 4; c++) begin
            for (int f = 0; f < 2; f++) begin
                for (int b = 0; b < 2; b++) begin
                    wr(ema_pkg::ADDR_FRAMING_SELECT, 8'(f * 64 + c * 4));
                    @(posedge core_clk);
                    tx_c1_in <= {1'b1, 1'(b)};
                    @(posedge core_clk);
                    tx_c1_in <= '0;
                    #1;
                    chk1("c1 strobe", 1'b1, tx_c1_out.stb);
                    chk1("c1 bit", 1'(b) ^ (f == 1 && c != 0), tx_c1_out.bit_val);
                end
            end
        end
    endtask : t_tx
    task automatic t_iw;
        wr(ema_pkg::ADDR_FRAMING_SELECT, 8'h04);
        rx_fas_present <= 1'b1;
        repeat (N_IW + 5) @(posedge core_clk);
        #1 chk1("interwork off", 1'b0, remote_no_crc4);
        rx_fas_present <= 1'b0;
        wr(ema_pkg::ADDR_FRAMING_SELECT, 8'h84);
        @(posedge core_clk);
        rx_fas_present <= 1'b1;
        repeat (N_IW - 1) @(posedge core_clk);
        #1 chk1("verdict early", 1'b0, remote_no_crc4);
        @(posedge core_clk);
        #1 chk1("verdict", 1'b1, remote_no_crc4);
        chk1("irq masked", 1'b0, irq);
        rd(ema_pkg::ADDR_INT_STATUS);
        chk1("iw status", 1'b1, rd_v[ema_pkg::EV_INTERWORK]);
        wr(ema_pkg::ADDR_INT_ENABLE, 8'h01);
        chk1("irq raised", 1'b1, irq);
        rx_fas_present <= 1'b0;
        wr(ema_pkg::ADDR_INT_CLEAR, 8'h01);
        chk1("irq cleared", 1'b0, irq);
        chk1("verdict dropped", 1'b0, remote_no_crc4);
    endtask : t_iw
    always @(posedge core_clk) begin
        n_cyc++;
        if (n_cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        {reg_wr, reg_rd, go, rx_fas_present, rx_crc_mf_aligned} = '0;
        {reg_addr, reg_wdata, n_miss} = '0;
        tx_c1_in = '0;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        t_regs();
        t_cas();
        t_tx();
        t_iw();
        complete_run();
    end
endmodule : test_ema_top
bind ema_top ema_top_properties #(.INTERWORK_CYCLES(INTERWORK_CYCLES)) ema_top_properties_i (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_frame(rx_frame), .rx_fas_present(rx_fas_present),
    .rx_crc_mf_aligned(rx_crc_mf_aligned), .tx_c1_in(tx_c1_in), .tx_c1_out(tx_c1_out),
    .crc_mf_enable(crc_mf_enable), .interwork_enable(interwork_enable),
    .remote_no_crc4(remote_no_crc4), .cas_mf_aligned(cas_mf_aligned),
    .cas_mf_loss(cas_mf_loss), .irq(irq));
`default_nettype wire
